// file: common/sto_pkg.sv
// Package: constants, states and carrier structs of the safe torque off interlock
package sto_pkg;

  // ----------------------------------------------------------------
  // Register map and layouts
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  localparam logic [3:0] OFF_CTRL   = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h1;
  localparam logic [3:0] OFF_IRQ_ST = 4'h2;
  localparam logic [3:0] OFF_IRQ_MK = 4'h3;

  // Control register bits
  localparam int unsigned CTRL_PROG_EN   = 0;
  localparam int unsigned CTRL_PROG_DIS  = 1;
  localparam int unsigned CTRL_FAULT_CLR = 2;

  // Status register bits
  localparam int unsigned ST_ENABLED = 0;
  localparam int unsigned ST_FAULT   = 1;
  localparam int unsigned ST_CH_ONE  = 2;
  localparam int unsigned ST_CH_TWO  = 3;
  localparam int unsigned ST_SAFE_ST = 4;
  localparam int unsigned ST_HW_EN   = 5;

  // Event bits
  localparam int unsigned EV_FAULT_REQ  = 0;
  localparam int unsigned EV_FAULT_DROP = 1;
  localparam int unsigned EV_ENABLED    = 2;
  localparam int unsigned EV_DISABLED   = 3;
  localparam int unsigned EV_W          = 4;

  localparam logic [EV_W-1:0] EV_RESET = 4'h0;
  localparam logic [EV_W-1:0] MK_RESET = 4'h0;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [1:0] SYNC_RESET = 2'h0;

  typedef enum logic [1:0] {
    ST_DISABLED,
    ST_RUN,
    ST_FAULTED
  } drive_state_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bus_req_s;

  typedef struct packed {
    logic one;
    logic two;
  } safety_pair_s;

endpackage : sto_pkg

// file: verilog/sto_interlock.sv
// Safe torque off enable interlock: synchronisers, drive state, registers, interrupt
//
// Overview of operation
// RL1: Power output stays off unless both safety channels are asserted together.
// RL2: While enabled, losing either or both safety channels disables the drive.
// RL3: Both channels asserted only permits enabling; a separate enable request is needed.
// RL4: Enable requests come from the hardware enable input or a program command.
// RL5: Enable request without both channels raises the safe torque fault instead.
// RL6: Channel drop while enabled switches power output off, stopping torque.
// RL7: Safety-channel disable enters the safe torque fault state, naming the cause.
// RL8: After a safety disable no braking is applied; the motor coasts.
// RL9: Hardware enable function sits on general digital input A3 by default.
// RL10: Interlock is active from reset; nothing runs until both channels assert.
// RL11: Safety status is high while at least one safety channel is asserted.
// RL12: Both channels and hardware enable are synchronised independently before use.
module sto_interlock (
  input  wire logic                        mclk,
  input  wire logic                        rst_b,
  input  wire sto_pkg::safety_pair_s       safety_in,
  input  wire logic                        hw_enable_input,
  input  wire sto_pkg::bus_req_s           bus_req,
  output logic [sto_pkg::DATA_W-1:0]       rdata,
  output logic                             power_output_en,
  output logic                             brake_cmd,
  output logic                             safe_torque_fault,
  output logic                             safety_status,
  output logic                             irq
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] sync_one_r;
  logic [1:0] sync_two_r;
  logic [1:0] sync_hw_r;
  logic       safety_channel_one;
  logic       safety_channel_two;
  logic       hw_en;
  logic       hw_en_prev_r;

  // Each pin has its own chain so one stuck channel cannot mask the other
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sync_one_r <= sto_pkg::SYNC_RESET;
      sync_two_r <= sto_pkg::SYNC_RESET;
      sync_hw_r  <= sto_pkg::SYNC_RESET;
    end else begin
      sync_one_r <= {sync_one_r[0], safety_in.one}; // RL12
      sync_two_r <= {sync_two_r[0], safety_in.two}; // RL12
      sync_hw_r  <= {sync_hw_r[0], hw_enable_input}; // RL9 RL12
    end
  end

  assign safety_channel_one = sync_one_r[1];
  assign safety_channel_two = sync_two_r[1];
  assign hw_en              = sync_hw_r[1];

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      hw_en_prev_r <= 1'b0;
    end else begin
      hw_en_prev_r <= hw_en;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // One decode for every write target keeps the offsets in one place
  function automatic logic wr_hit(
    input sto_pkg::bus_req_s          req,
    input logic [sto_pkg::ADDR_W-1:0] off
  );
    return req.wr && (req.addr == off);
  endfunction : wr_hit

  logic ctrl_wr;
  logic prog_en_cmd;
  logic prog_dis_cmd;
  logic fault_clr_cmd;
  logic hw_rise;
  logic enable_req;
  logic both_ok;

  assign ctrl_wr       = wr_hit(bus_req, sto_pkg::OFF_CTRL);
  assign prog_en_cmd   = ctrl_wr && bus_req.wdata[sto_pkg::CTRL_PROG_EN];
  assign prog_dis_cmd  = ctrl_wr && bus_req.wdata[sto_pkg::CTRL_PROG_DIS];
  assign fault_clr_cmd = ctrl_wr && bus_req.wdata[sto_pkg::CTRL_FAULT_CLR];
  // Edge, not level: a held switch must not re-enable after a fault clear
  assign hw_rise       = hw_en && !hw_en_prev_r;
  assign enable_req    = hw_rise || prog_en_cmd; // RL4
  assign both_ok       = safety_channel_one && safety_channel_two;

  // ----------------------------------------------------------------
  // Drive state
  // ----------------------------------------------------------------
  sto_pkg::drive_state_e state_r;
  sto_pkg::drive_state_e state_nxt;
  logic                  ev_fault_req;
  logic                  ev_fault_drop;

  always_comb begin
    state_nxt     = state_r;
    ev_fault_req  = 1'b0;
    ev_fault_drop = 1'b0;
    case (state_r)
      sto_pkg::ST_DISABLED: begin
        if (enable_req) begin
          if (both_ok) begin
            state_nxt = sto_pkg::ST_RUN; // RL3
          end else begin
            state_nxt    = sto_pkg::ST_FAULTED; // RL5
            ev_fault_req = 1'b1;
          end
        end
      end
      sto_pkg::ST_RUN: begin
        if (!both_ok) begin
          state_nxt     = sto_pkg::ST_FAULTED; // RL2 RL7
          ev_fault_drop = 1'b1;
        end else if (prog_dis_cmd || !hw_en) begin
          state_nxt = sto_pkg::ST_DISABLED;
        end
      end
      sto_pkg::ST_FAULTED: begin
        if (fault_clr_cmd) begin
          state_nxt = sto_pkg::ST_DISABLED;
        end
      end
      default: begin
        state_nxt = sto_pkg::ST_DISABLED;
      end
    endcase
  end

  // Reset lands in the disabled state, so the interlock guards from the start
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_r <= sto_pkg::ST_DISABLED; // RL10
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Power gating also looks at the synchronised channels directly; the registered output
  // drops on the clock edge after the synchronised channel falls
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      power_output_en   <= 1'b0;
      safe_torque_fault <= 1'b0;
      safety_status     <= 1'b0;
    end else begin
      power_output_en   <= (state_nxt == sto_pkg::ST_RUN) && both_ok; // RL1 RL6
      safe_torque_fault <= (state_nxt == sto_pkg::ST_FAULTED); // RL7
      safety_status     <= safety_channel_one || safety_channel_two; // RL11
    end
  end

  // No controlled stop exists in this block: the motor simply coasts
  assign brake_cmd = 1'b0; // RL8

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  logic [sto_pkg::EV_W-1:0] irq_st_r;
  logic [sto_pkg::EV_W-1:0] irq_mk_r;
  logic [sto_pkg::EV_W-1:0] ev_set;
  logic [sto_pkg::EV_W-1:0] ev_clr;

  always_comb begin
    ev_set = sto_pkg::EV_RESET;
    ev_set[sto_pkg::EV_FAULT_REQ]  = ev_fault_req;
    ev_set[sto_pkg::EV_FAULT_DROP] = ev_fault_drop;
    ev_set[sto_pkg::EV_ENABLED]    = (state_r != sto_pkg::ST_RUN)
                                     && (state_nxt == sto_pkg::ST_RUN);
    ev_set[sto_pkg::EV_DISABLED]   = (state_r == sto_pkg::ST_RUN)
                                     && (state_nxt != sto_pkg::ST_RUN);
  end

  assign ev_clr = wr_hit(bus_req, sto_pkg::OFF_IRQ_ST)
                  ? bus_req.wdata[sto_pkg::EV_W-1:0] : sto_pkg::EV_RESET;

  // Set wins over a simultaneous write-one-to-clear
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      irq_st_r <= sto_pkg::EV_RESET;
    end else begin
      irq_st_r <= (irq_st_r & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      irq_mk_r <= sto_pkg::MK_RESET;
    end else if (wr_hit(bus_req, sto_pkg::OFF_IRQ_MK)) begin
      irq_mk_r <= bus_req.wdata[sto_pkg::EV_W-1:0];
    end
  end

  assign irq = |(irq_st_r & irq_mk_r);

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [sto_pkg::DATA_W-1:0] status_word;

  always_comb begin
    status_word = sto_pkg::DATA_ZERO;
    status_word[sto_pkg::ST_ENABLED] = power_output_en;
    status_word[sto_pkg::ST_FAULT]   = safe_torque_fault;
    status_word[sto_pkg::ST_CH_ONE]  = safety_channel_one;
    status_word[sto_pkg::ST_CH_TWO]  = safety_channel_two;
    status_word[sto_pkg::ST_SAFE_ST] = safety_status;
    status_word[sto_pkg::ST_HW_EN]   = hw_en;
  end

  // Control bits are self-clearing commands, so the control word reads zero
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rdata <= sto_pkg::DATA_ZERO;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        sto_pkg::OFF_STATUS: rdata <= status_word;
        sto_pkg::OFF_IRQ_ST: rdata <= {{(sto_pkg::DATA_W - sto_pkg::EV_W){1'b0}}, irq_st_r};
        sto_pkg::OFF_IRQ_MK: rdata <= {{(sto_pkg::DATA_W - sto_pkg::EV_W){1'b0}}, irq_mk_r};
        default:             rdata <= sto_pkg::DATA_ZERO;
      endcase
    end else begin
      rdata <= sto_pkg::DATA_ZERO;
    end
  end

endmodule : sto_interlock

// file: verification/sto_interlock_monitor.sv
// Checker: port relations of the enable interlock
module sto_interlock_monitor (
  input wire logic                        mclk,
  input wire logic                        rst_b,
  input wire sto_pkg::safety_pair_s       safety_in,
  input wire logic                        hw_enable_input,
  input wire sto_pkg::bus_req_s           bus_req,
  input wire logic [sto_pkg::DATA_W-1:0]  rdata,
  input wire logic                        power_output_en,
  input wire logic                        brake_cmd,
  input wire logic                        safe_torque_fault,
  input wire logic                        safety_status,
  input wire logic                        irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] up_r;
  wire both = safety_in.one && safety_in.two;
  wire ctrl_en = bus_req.wr && bus_req.addr == sto_pkg::OFF_CTRL && bus_req.wdata[0];
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // Synchronisers need a few edges after reset before outputs track pins
  always_ff @(posedge mclk) begin
    if (!rst_b) up_r <= 3'h0;
    else if (up_r != 3'h7) up_r <= up_r + 3'h1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_drop; power_output_en && !both; endsequence
  sequence s_bad_req; !hw_enable_input ##1 (hw_enable_input && !both && !power_output_en);
  endsequence
  a_no_brake: assert property (brake_cmd == 1'b0)
    else $error("brake output driven");
  a_power_both: assert property (power_output_en |-> $past(both, 3))
    else $error("power on without both channels");
  a_drop_fault: assert property (s_drop |-> ##3 (!power_output_en && safe_torque_fault))
    else $error("channel drop did not fault");
  a_req_fault: assert property (s_bad_req |-> ##3 (safe_torque_fault && !power_output_en))
    else $error("bad request did not fault");
  a_enable_cause: assert property ($rose(power_output_en) |->
    ($past(hw_enable_input, 3) && !$past(hw_enable_input, 4)) || $past(ctrl_en, 1)
    || $past(ctrl_en, 2)) else $error("enable without request");
  a_status_or: assert property (up_r == 3'h7 |->
    safety_status == $past(safety_in.one || safety_in.two, 3)) else $error("status mismatch");
  a_status_rd: assert property ($past(bus_req.rd && bus_req.addr == sto_pkg::OFF_STATUS) |->
    rdata[sto_pkg::ST_ENABLED] == $past(power_output_en) &&
    rdata[sto_pkg::ST_FAULT] == $past(safe_torque_fault)) else $error("status read wrong");
  a_fault_off: assert property (safe_torque_fault |-> !power_output_en)
    else $error("power on in fault");
endmodule : sto_interlock_monitor
bind sto_interlock sto_interlock_monitor i_mon (.mclk(mclk), .rst_b(rst_b),
  .safety_in(safety_in), .hw_enable_input(hw_enable_input), .bus_req(bus_req),
  .rdata(rdata), .power_output_en(power_output_en), .brake_cmd(brake_cmd),
  .safe_torque_fault(safe_torque_fault), .safety_status(safety_status), .irq(irq));

// file: verification/sto_safety_ctrl.sv
// Model of the external safety controller and enable switch
module sto_safety_ctrl (
  input  wire logic             mclk,
  input  wire logic [1:0]       ch_cmd,
  input  wire logic             en_cmd,
  output sto_pkg::safety_pair_s safety_in,
  output logic                  hw_enable_input
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pins are levels held between commands, as a relay contact would be
  initial begin
    safety_in = '0;
    hw_enable_input = 1'b0;
  end
  always @(posedge mclk) begin
    safety_in <= ch_cmd;
    hw_enable_input <= en_cmd;
  end
endmodule : sto_safety_ctrl

// file: verification/sto_interlock_bench.sv
// Testbench: pin and register stimulus with scoreboarded reads
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module sto_interlock_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, rst_b = 1'b0, en = 1'b0, rd_seen = 1'b0;
  logic [1:0] ch = 2'h0;
  logic [7:0] rdata, e, rnd = 8'h5A;
  logic power_output_en, brake_cmd, safe_torque_fault, safety_status, irq, hw_enable_input;
  sto_pkg::bus_req_s bus_req = '0;
  sto_pkg::safety_pair_s safety_in;
  int error_cnt = 0, checks = 0;
  logic [7:0] exp_q[$];
  initial forever #5 mclk = ~mclk;
  sto_safety_ctrl i_sto_safety_ctrl (.mclk(mclk), .ch_cmd(ch), .en_cmd(en),
    .safety_in(safety_in), .hw_enable_input(hw_enable_input));
  sto_interlock i_sto_interlock (.mclk(mclk), .rst_b(rst_b), .safety_in(safety_in),
    .hw_enable_input(hw_enable_input), .bus_req(bus_req), .rdata(rdata),
    .power_output_en(power_output_en), .brake_cmd(brake_cmd),
    .safe_torque_fault(safe_torque_fault), .safety_status(safety_status), .irq(irq));
  function automatic logic [7:0] st(logic p, logic f, logic h);
    return {2'h0, h, |ch, ch[0], ch[1], f, p};
  endfunction : st
  // ----------------------------------------------------------------
  // Drivers and read scoreboard
  // ----------------------------------------------------------------
  task automatic bus(logic r, logic [3:0] a, logic [7:0] d);
    @(posedge mclk) bus_req <= {a, d, !r, r};
    if (r) exp_q.push_back(d);
    @(posedge mclk) bus_req <= '0;
  endtask : bus
  task automatic pins(logic [1:0] c, logic n);
    @(posedge mclk) ch <= c;
    en <= n;
    repeat (6) @(posedge mclk);
    #1;
  endtask : pins
  task automatic wait_pw(logic v);
    #1;
    for (int n = 0; n < 10 && power_output_en !== v; n++) @(posedge mclk) #1;
    `CHK(power_output_en, v)
    if (power_output_en !== v) stop_test();
  endtask : wait_pw
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  always @(posedge mclk) begin
    if (rd_seen) begin
      e = exp_q.pop_front();
      `CHK(rdata, e)
    end
    rd_seen = bus_req.rd;
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    #1 `CHK({power_output_en, safe_torque_fault, irq}, 3'h0)
    bus(0, sto_pkg::OFF_IRQ_MK, 8'h0F);
    pins(2'h0, 1'b1);
    `CHK({safe_torque_fault, power_output_en, irq}, 3'h5)
    bus(1, sto_pkg::OFF_IRQ_ST, 8'h01);
    bus(1, sto_pkg::OFF_STATUS, st(0, 1, 1));
    bus(0, sto_pkg::OFF_IRQ_MK, 8'h00);
    #1 `CHK(irq, 1'b0)
    bus(0, sto_pkg::OFF_IRQ_MK, 8'h0F);
    pins(2'h0, 1'b0);
    bus(0, sto_pkg::OFF_IRQ_ST, 8'h0F);
    bus(0, sto_pkg::OFF_CTRL, 8'h04);
    pins(2'h2, 1'b0);
    bus(1, sto_pkg::OFF_STATUS, st(0, 0, 0));
    pins(2'h3, 1'b0);
    `CHK({power_output_en, safety_status, irq}, 3'h2)
    pins(2'h3, 1'b1);
    wait_pw(1'b1);
    bus(0, sto_pkg::OFF_CTRL, 8'h02);
    wait_pw(1'b0);
    bus(1, sto_pkg::OFF_IRQ_ST, 8'h0C);
    bus(0, sto_pkg::OFF_IRQ_ST, 8'h0F);
    bus(0, sto_pkg::OFF_CTRL, 8'h01);
    wait_pw(1'b1);
    $display("enable tests done");
    for (int k = 0; k < 3; k++) begin
      rnd = lfsr(rnd);
      bus(0, 4'h4 | rnd[3:0], rnd);
      bus(1, 4'h4 | rnd[3:0], 8'h00);
      bus(0, sto_pkg::OFF_IRQ_ST, 8'h0F);
      pins(k[1:0], 1'b1);
      `CHK({power_output_en, safe_torque_fault, brake_cmd, irq}, 4'h5)
      bus(1, sto_pkg::OFF_IRQ_ST, 8'h0A);
      pins(2'h3, 1'b0);
      bus(0, sto_pkg::OFF_CTRL, 8'h04);
      bus(0, sto_pkg::OFF_IRQ_ST, 8'h0F);
      pins(2'h3, 1'b1);
      wait_pw(1'b1);
    end
    $display("drop tests done");
    stop_test();
  end
  function automatic logic [7:0] lfsr(logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr
endmodule : sto_interlock_bench
